// File: src/ipv_pkg.sv
// Constants, field positions and types for the interrupt vectoring block
package ipv_pkg;
  // Register offsets
  localparam logic [7:0] TIMER_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] IEN_OFS = 8'h01;
  localparam logic [7:0] IPRI_OFS = 8'h02;
  localparam logic [7:0] SER_OFS = 8'h03;
  localparam logic [7:0] PWR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h05;
  // timer_control_reg fields
  localparam int TF1_BIT = 7;
  localparam int TF0_BIT = 5;
  localparam int EF1_BIT = 3;
  localparam int TS1_BIT = 2;
  localparam int EF0_BIT = 1;
  localparam int TS0_BIT = 0;
  // interrupt_enable_reg global enable, serial and power fields
  localparam int GEN_BIT = 7;
  localparam int TX_BIT = 1;
  localparam int RX_BIT = 0;
  localparam int IDLE_BIT = 0;
  // Reset values
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [4:0] IPRI_RST = 5'h00;
  // Source indices in polling order
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;
  localparam logic [2:0] SRC_SER = 3'h4;
  // Machine cycle timing: 12 clocks, state5_phase2 is phase index 9
  localparam int MC_CLKS = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
  localparam logic [3:0] PH_STATE5_PHASE2 = 4'h9;
  localparam int CALL_MCS = 2;
  localparam int CALL_CLKS = CALL_MCS * MC_CLKS;
  localparam logic [4:0] CALL_LAST = 5'(CALL_CLKS - 1);

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_CALL1 = 2'h1,
    ST_CALL2 = 2'h3
  } ipv_state_t;

  function automatic logic [15:0] ipv_vector(input logic [2:0] src);
    case (src)
      SRC_EXT0: ipv_vector = 16'h0003;
      SRC_TMR0: ipv_vector = 16'h000b;
      SRC_EXT1: ipv_vector = 16'h0013;
      SRC_TMR1: ipv_vector = 16'h001b;
      default: ipv_vector = 16'h0023;
    endcase
  endfunction
endpackage

// File: src/ipv_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ipv_pin_sync import ipv_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ipv_sync_t;

  ipv_sync_t st_r;
  ipv_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Pin idles high; a change counts once stages two and three agree
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
endmodule

// File: src/ipv_arbiter.sv
// Two-level priority arbiter with fixed polling order inside a level
`timescale 1ns/1ps
module ipv_arbiter import ipv_pkg::*; (
  // Requests and their levels
  input wire logic [4:0] req,
  input wire logic [4:0] prio,
  input wire logic [1:0] in_prog,
  // Grant
  output logic grant,
  output logic [2:0] grant_src,
  output logic grant_hi
);
  logic [4:0] hi_req;
  logic [4:0] lo_req;

  always_comb begin
    // Only a level above every routine in progress may be taken
    hi_req = (in_prog[1]) ? 5'h00 : (req & prio);
    lo_req = (in_prog != 2'h0) ? 5'h00 : (req & ~prio);
    grant = 1'b0;
    grant_src = SRC_SER;
    grant_hi = 1'b0;
    if (hi_req != 5'h00) begin
      grant = 1'b1;
      grant_hi = 1'b1;
      for (int i = 4; i >= 0; i--) begin
        if (hi_req[i]) begin
          grant_src = 3'(i);
        end
      end
    end else if (lo_req != 5'h00) begin
      grant = 1'b1;
      for (int i = 4; i >= 0; i--) begin
        if (lo_req[i]) begin
          grant_src = 3'(i);
        end
      end
    end
  end
endmodule

// File: src/ipv_ctrl.sv
// Interrupt sampling, arbitration, vectoring and in-progress tracking
//
// Summary of operation
// (RULE1) Higher level wins simultaneous requests
// (RULE2) Equal level: ext0, tmr0, ext1, tmr1, serial
// (RULE3) Polling order never preempts running routine
// (RULE4) Ack issues long call pushing PC only
// (RULE5) PC loaded with fixed per-source vector
// (RULE6) Return-from-interrupt clears level, pops PC
// (RULE7) Plain return leaves in-progress set
// (RULE8) Trigger select zero: low level requests
// (RULE9) Trigger select one: high-then-low sets flag
// (RULE10) Source holds levels twelve oscillator periods
// (RULE11) Edge source: high one cycle, low one
// (RULE12) Edge flag cleared when call made
// (RULE13) Level source releases before routine ends
// (RULE14) Pins inverted, latched state5_phase2, polled next
// (RULE15) Call next, two machine cycles long
// (RULE16) Equal or higher level in progress blocks
// (RULE17) Ack waits for instruction final cycle
// (RULE18) Return or enable/priority access defers ack
// (RULE19) Ack and reset clear idle bit
// (RULE20) Per-source level bit, enables, global enable
// (RULE21) Serial flags ORed, cleared by software only
`timescale 1ns/1ps
module ipv_ctrl import ipv_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // External request pins
  input wire logic ext0_request_pin,
  input wire logic ext1_request_pin,
  // Peripheral events
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic ser_rx_done,
  input wire logic ser_tx_done,
  // Core sequencer status
  input wire logic instr_final,
  input wire logic instr_block,
  input wire logic instr_return_from_interrupt,
  input wire logic instr_ret,
  // Core sequencer commands
  output logic long_call,
  output logic pc_push,
  output logic pc_pop,
  output logic [15:0] call_vector,
  output logic idle_mode,
  output logic [1:0] irq_in_progress,
  output logic [4:0] machine_phase
);
  typedef struct packed {
    logic [3:0] phase;
    logic [4:0] call_cnt;
    ipv_state_t st;
    logic [1:0] trig;
    logic [1:0] ext_flag;
    logic [1:0] ext_prev;
    logic [1:0] tmr_flag;
    logic [1:0] ser_flag;
    logic [7:0] ien;
    logic [4:0] ipri;
    logic idle;
    logic [1:0] in_prog;
    logic [2:0] act_src;
    logic [4:0] pend;
    logic [7:0] rdata;
    logic [15:0] vec;
    logic push;
    logic pop;
  } ipv_ctrl_t;

  ipv_ctrl_t st_r;
  ipv_ctrl_t st_nxt;
  logic ext0_lvl;
  logic ext1_lvl;
  logic [4:0] req;
  logic grant;
  logic [2:0] grant_src;
  logic grant_hi;
  logic ack;
  logic [7:0] timer_control_reg_val;

  ipv_pin_sync u_sync0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(ext0_request_pin),
    .level(ext0_lvl)
  );

  ipv_pin_sync u_sync1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(ext1_request_pin),
    .level(ext1_lvl)
  );

  // Enabled requests in polling order
  always_comb begin
    req[SRC_EXT0] = st_r.ext_flag[0] & st_r.ien[SRC_EXT0]; // [RULE20]
    req[SRC_TMR0] = st_r.tmr_flag[0] & st_r.ien[SRC_TMR0];
    req[SRC_EXT1] = st_r.ext_flag[1] & st_r.ien[SRC_EXT1];
    req[SRC_TMR1] = st_r.tmr_flag[1] & st_r.ien[SRC_TMR1];
    req[SRC_SER] = (|st_r.ser_flag) & st_r.ien[SRC_SER]; // [RULE21]
    if (!st_r.ien[GEN_BIT]) begin
      req = 5'h00;
    end
  end

  // Arbitrates the snapshot polled one machine cycle after latching
  ipv_arbiter u_arb (
    .req(st_r.pend),
    .prio(st_r.ipri),
    .in_prog(st_r.in_prog),
    .grant(grant),
    .grant_src(grant_src),
    .grant_hi(grant_hi)
  ); // [RULE1] [RULE2] [RULE3] [RULE16]

  // Ack only at the end of the instruction's final machine cycle
  assign ack = (st_r.phase == MC_LAST) && (st_r.st == ST_RUN) && grant &&
               instr_final && !instr_block; // [RULE17] [RULE18]

  always_comb begin
    timer_control_reg_val = 8'h00;
    timer_control_reg_val[TF1_BIT] = st_r.tmr_flag[1];
    timer_control_reg_val[TF0_BIT] = st_r.tmr_flag[0];
    timer_control_reg_val[EF1_BIT] = st_r.ext_flag[1];
    timer_control_reg_val[TS1_BIT] = st_r.trig[1];
    timer_control_reg_val[EF0_BIT] = st_r.ext_flag[0];
    timer_control_reg_val[TS0_BIT] = st_r.trig[0];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.push = 1'b0;
    st_nxt.pop = 1'b0;
    st_nxt.phase = (st_r.phase == MC_LAST) ? 4'h0 : st_r.phase + 4'h1;

    // Software writes first; hardware events below win over clears
    if (bus_wr) begin
      case (bus_addr)
        TIMER_CONTROL_REG_OFS: begin
          st_nxt.tmr_flag = {bus_wdata[TF1_BIT], bus_wdata[TF0_BIT]};
          st_nxt.ext_flag = {bus_wdata[EF1_BIT], bus_wdata[EF0_BIT]};
          st_nxt.trig = {bus_wdata[TS1_BIT], bus_wdata[TS0_BIT]};
        end
        IEN_OFS: st_nxt.ien = bus_wdata & 8'h9f; // [RULE20]
        IPRI_OFS: st_nxt.ipri = bus_wdata[4:0];
        SER_OFS: st_nxt.ser_flag = {bus_wdata[TX_BIT], bus_wdata[RX_BIT]};
        PWR_OFS: st_nxt.idle = bus_wdata[IDLE_BIT];
        default: ;
      endcase
    end

    // Pin latch at state5_phase2, inverted
    if (st_r.phase == PH_STATE5_PHASE2) begin // [RULE14]
      st_nxt.ext_prev = {ext1_lvl, ext0_lvl};
      for (int i = 0; i < 2; i++) begin
        if (!st_nxt.trig[i]) begin
          st_nxt.ext_flag[i] = ~(i == 0 ? ext0_lvl : ext1_lvl); // [RULE8]
        end else if (st_r.ext_prev[i] && !(i == 0 ? ext0_lvl : ext1_lvl)) begin
          st_nxt.ext_flag[i] = 1'b1; // [RULE9]
        end
      end
    end

    // Poll snapshot taken at the end of the machine cycle
    if (st_r.phase == MC_LAST) begin
      st_nxt.pend = req; // [RULE14]
    end

    case (st_r.st)
      ST_RUN: begin
        if (ack) begin
          st_nxt.st = ST_CALL1; // [RULE15]
          st_nxt.call_cnt = 5'h00;
          st_nxt.act_src = grant_src;
          st_nxt.vec = ipv_vector(grant_src); // [RULE5]
          st_nxt.push = 1'b1; // [RULE4]
          st_nxt.idle = 1'b0; // [RULE19]
          st_nxt.pend = 5'h00;
          if (grant_hi) begin
            st_nxt.in_prog[1] = 1'b1;
          end else begin
            st_nxt.in_prog[0] = 1'b1;
          end
          // Edge flags and timer flags cleared by the call; serial kept
          if (grant_src == SRC_EXT0 && st_r.trig[0]) begin
            st_nxt.ext_flag[0] = 1'b0; // [RULE12]
          end
          if (grant_src == SRC_EXT1 && st_r.trig[1]) begin
            st_nxt.ext_flag[1] = 1'b0; // [RULE12]
          end
          if (grant_src == SRC_TMR0) begin
            st_nxt.tmr_flag[0] = 1'b0;
          end
          if (grant_src == SRC_TMR1) begin
            st_nxt.tmr_flag[1] = 1'b0;
          end
        end
      end
      ST_CALL1: begin
        st_nxt.call_cnt = st_r.call_cnt + 5'h01;
        if (st_r.call_cnt == 5'(MC_CLKS - 1)) begin
          st_nxt.st = ST_CALL2;
        end
      end
      ST_CALL2: begin
        st_nxt.call_cnt = st_r.call_cnt + 5'h01;
        if (st_r.call_cnt == CALL_LAST) begin
          st_nxt.st = ST_RUN; // [RULE15]
        end
      end
      default: st_nxt.st = ST_RUN;
    endcase

    // Return-from-interrupt frees the active level; plain return does not
    if (instr_return_from_interrupt) begin
      st_nxt.pop = 1'b1; // [RULE6]
      if (st_r.in_prog[1]) begin
        st_nxt.in_prog[1] = 1'b0;
      end else begin
        st_nxt.in_prog[0] = 1'b0;
      end
    end // [RULE7]

    // Hardware set beats software clear
    if (tmr0_ovf) begin
      st_nxt.tmr_flag[0] = 1'b1;
    end
    if (tmr1_ovf) begin
      st_nxt.tmr_flag[1] = 1'b1;
    end
    if (ser_rx_done) begin
      st_nxt.ser_flag[RX_BIT] = 1'b1;
    end
    if (ser_tx_done) begin
      st_nxt.ser_flag[TX_BIT] = 1'b1;
    end

    // Registered read data, zero for unmapped
    st_nxt.rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        TIMER_CONTROL_REG_OFS: st_nxt.rdata = timer_control_reg_val;
        IEN_OFS: st_nxt.rdata = st_r.ien;
        IPRI_OFS: st_nxt.rdata = {3'h0, st_r.ipri};
        SER_OFS: st_nxt.rdata = {6'h00, st_r.ser_flag};
        PWR_OFS: st_nxt.rdata = {7'h00, st_r.idle};
        STAT_OFS: st_nxt.rdata = {1'b0, st_r.act_src, 2'h0, st_r.in_prog};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.st <= ST_RUN;
      st_r.ien <= IEN_RST;
      st_r.ipri <= IPRI_RST;
      st_r.ext_prev <= 2'h3;
      st_r.idle <= 1'b0; // [RULE19]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign long_call = (st_r.st != ST_RUN);
  assign pc_push = st_r.push;
  assign pc_pop = st_r.pop;
  assign call_vector = st_r.vec;
  assign idle_mode = st_r.idle;
  assign irq_in_progress = st_r.in_prog;
  assign machine_phase = {1'b0, st_r.phase};

  // Checks
  sequence s_call_hold;
    long_call [*8] ##16 long_call ##1 !long_call;
  endsequence

  sequence s_ack_seen;
    ack ##1 pc_push;
  endsequence

  chk_call_len: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
    $rose(long_call) |-> s_call_hold)
    else $error("Long call not two machine cycles");

  chk_call_vec: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    s_ack_seen |-> call_vector == ipv_vector($past(grant_src)) && long_call)
    else $error("Wrong vector loaded");

  chk_level_first: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    ack && (st_r.pend & st_r.ipri) != 5'h00 && !st_r.in_prog[1] |-> grant_hi)
    else $error("Lower level served over higher");

  chk_poll_order: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    ack |-> ((st_r.pend & ((5'h01 << grant_src) - 5'h01) &
      (grant_hi ? st_r.ipri : ~st_r.ipri)) == 5'h00))
    else $error("Polling order violated");

  chk_no_preempt: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    ack |-> !st_r.in_prog[1] && (grant_hi || st_r.in_prog == 2'h0))
    else $error("Ack while equal or higher level in progress");

  chk_ack_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
    ack |-> instr_final && !instr_block && st_r.phase == MC_LAST)
    else $error("Ack outside final cycle or while deferred");

  chk_idle_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE19]
    ack |=> !idle_mode && pc_push)
    else $error("Idle bit not cleared on ack");

  chk_return_from_interrupt_free: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
    instr_return_from_interrupt && irq_in_progress[1] && !ack |=> !irq_in_progress[1] && pc_pop)
    else $error("Return-from-interrupt did not free level");

  chk_ret_keep: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
    instr_ret && !instr_return_from_interrupt && !ack |=> irq_in_progress == $past(irq_in_progress))
    else $error("Plain return changed in-progress state");

  chk_edge_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
    ack && grant_src == SRC_EXT0 && st_r.trig[0] && st_r.phase != PH_STATE5_PHASE2 |=>
      !st_r.ext_flag[0])
    else $error("Edge flag not cleared by call");

  // Latch behaviour of external zero at state5_phase2, no software write in the way
  chk_level_latch: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    st_r.phase == PH_STATE5_PHASE2 && !st_r.trig[0] && !bus_wr |=>
      st_r.ext_flag[0] == !$past(ext0_lvl))
    else $error("Level mode flag does not follow pin");

  chk_edge_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
    st_r.phase == PH_STATE5_PHASE2 && st_r.trig[0] && !bus_wr && st_r.ext_prev[0] && !ext0_lvl |=>
      st_r.ext_flag[0])
    else $error("Edge mode flag not set on high then low");

  chk_ser_kept: assert property (@(posedge clk) disable iff (sys_rst) // [RULE21]
    ack && !bus_wr |=> (st_r.ser_flag & $past(st_r.ser_flag)) == $past(st_r.ser_flag))
    else $error("Serial flag cleared by hardware");
endmodule

// File: dv/ipv_core_model.sv
// Core sequencer stand-in: instruction timing, block window and return stack depth
`timescale 1ns/1ps
module ipv_core_model import ipv_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Controller outputs
  input wire logic [4:0] machine_phase,
  input wire logic pc_push,
  input wire logic pc_pop,
  // Bench controls
  input wire logic [2:0] instr_mcs,
  input wire logic hold_block,
  // Sequencer status
  output logic instr_final,
  output logic instr_block,
  output logic [3:0] stack_depth
);
  logic [2:0] mc_cnt_r;
  logic [3:0] depth_r;
  // One step per machine cycle; wraps after the instruction's last cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mc_cnt_r <= 3'h0;
      depth_r <= 4'h0;
    end else begin
      if (machine_phase == {1'b0, MC_LAST}) begin
        mc_cnt_r <= instr_final ? 3'h0 : mc_cnt_r + 3'h1;
      end
      depth_r <= depth_r + {3'h0, pc_push} - {3'h0, pc_pop};
    end
  end
  assign instr_final = (mc_cnt_r + 3'h1 >= instr_mcs);
  assign instr_block = hold_block;
  assign stack_depth = depth_r;
endmodule

// File: dv/ipv_ctrl_tb.sv
// Self-checking bench for the interrupt vectoring controller
`timescale 1ns/1ps
module ipv_ctrl_tb import ipv_pkg::*; ();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic ext0_pin = 1'b1;
  logic ext1_pin = 1'b1;
  logic [3:0] ev = 4'h0;
  logic return_from_interrupt_p = 1'b0;
  logic ret_p = 1'b0;
  logic [2:0] instr_mcs = 3'h1;
  logic hold_block = 1'b0;
  logic [7:0] bus_rdata;
  logic long_call, pc_push, pc_pop, idle_mode, instr_final, instr_block;
  logic [15:0] call_vector;
  logic [1:0] irq_in_progress;
  logic [4:0] machine_phase;
  logic [3:0] stack_depth;
  int errors = 0;
  int checks = 0;

  always #5 clk = ~clk;

  ipv_ctrl i_ipv_ctrl (
    .clk(clk), .sys_rst(sys_rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .ext0_request_pin(ext0_pin), .ext1_request_pin(ext1_pin),
    .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .ser_rx_done(ev[2]), .ser_tx_done(ev[3]),
    .instr_final(instr_final), .instr_block(instr_block),
    .instr_return_from_interrupt(return_from_interrupt_p), .instr_ret(ret_p),
    .long_call(long_call), .pc_push(pc_push), .pc_pop(pc_pop),
    .call_vector(call_vector), .idle_mode(idle_mode),
    .irq_in_progress(irq_in_progress), .machine_phase(machine_phase)
  );

  ipv_core_model i_ipv_core_model (
    .clk(clk), .sys_rst(sys_rst), .machine_phase(machine_phase),
    .pc_push(pc_push), .pc_pop(pc_pop), .instr_mcs(instr_mcs),
    .hold_block(hold_block), .instr_final(instr_final),
    .instr_block(instr_block), .stack_depth(stack_depth)
  );

  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, bus_rdata});
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  task automatic expect_call(input logic [15:0] vec, input logic [1:0] prog);
    int n;
    n = 0;
    while (pc_push !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 200) begin
        chk("call_wait", 16'h0001, 16'h0000);
        results();
      end
    end
    chk("call_vector", vec, call_vector);
    chk("in_progress", {14'h0, prog}, {14'h0, irq_in_progress});
    chk("idle_mode", 16'h0000, {15'h0, idle_mode});
    chk("machine_phase", 16'h0000, {11'h0, machine_phase});
    n = 0;
    while (long_call === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("long_call_clks", 16'h0018, 16'(n));
  endtask

  task automatic expect_none(input int cycles);
    int k;
    k = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (pc_push === 1'b1) k++;
    end
    chk("stray_calls", 16'h0000, 16'(k));
  endtask

  task automatic ret_op(input logic is_return_from_interrupt, input logic [1:0] prog);
    @(posedge clk);
    if (is_return_from_interrupt) return_from_interrupt_p <= 1'b1;
    else ret_p <= 1'b1;
    @(posedge clk);
    return_from_interrupt_p <= 1'b0;
    ret_p <= 1'b0;
    #1;
    chk("pc_pop", {15'h0, is_return_from_interrupt}, {15'h0, pc_pop});
    chk("in_progress", {14'h0, prog}, {14'h0, irq_in_progress});
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IEN_OFS, 8'h00);
    rd(IPRI_OFS, 8'h00);
    rd(PWR_OFS, 8'h00);
    rd(8'h07, 8'h00);
    wr(IEN_OFS, 8'hff);
    rd(IEN_OFS, 8'h9f);
    // One source at a time, level mode for the pins
    for (int i = 0; i < 5; i++) begin
      wr(PWR_OFS, 8'h01);
      rd(PWR_OFS, 8'h01);
      case (i)
        0: ext0_pin <= 1'b0;
        2: ext1_pin <= 1'b0;
        4: pulse(4'h8);
        default: pulse(i == 1 ? 4'h1 : 4'h2);
      endcase
      expect_call(16'h0003 + 16'(i * 8), 2'h1);
      ext0_pin <= 1'b1;
      ext1_pin <= 1'b1;
      if (i == 4) begin
        rd(SER_OFS, 8'h02);
        rd(STAT_OFS, 8'h41);
        wr(SER_OFS, 8'h00);
      end
      repeat (40) @(posedge clk);
      ret_op(1'b1, 2'h0);
    end
    // Simultaneous requests on one level
    pulse(4'h7);
    expect_call(16'h000b, 2'h1);
    ret_op(1'b1, 2'h0);
    expect_call(16'h001b, 2'h1);
    ret_op(1'b1, 2'h0);
    expect_call(16'h0023, 2'h1);
    wr(SER_OFS, 8'h00);
    repeat (30) @(posedge clk);
    ret_op(1'b1, 2'h0);
    // Timer one on the high level
    wr(IPRI_OFS, 8'h08);
    pulse(4'h3);
    expect_call(16'h001b, 2'h2);
    expect_none(60);
    ret_op(1'b1, 2'h0);
    expect_call(16'h000b, 2'h1);
    pulse(4'h2);
    expect_call(16'h001b, 2'h3);
    ret_op(1'b1, 2'h1);
    ret_op(1'b1, 2'h0);
    // Polling order never preempts a running routine
    wr(IPRI_OFS, 8'h00);
    pulse(4'h2);
    expect_call(16'h001b, 2'h1);
    pulse(4'h1);
    expect_none(60);
    ret_op(1'b1, 2'h0);
    expect_call(16'h000b, 2'h1);
    ret_op(1'b0, 2'h1);
    pulse(4'h1);
    expect_none(60);
    ret_op(1'b1, 2'h0);
    expect_call(16'h000b, 2'h1);
    ret_op(1'b1, 2'h0);
    // Global enable, blocked and long instructions
    wr(IEN_OFS, 8'h1f);
    pulse(4'h1);
    expect_none(60);
    hold_block <= 1'b1;
    wr(IEN_OFS, 8'h9f);
    expect_none(60);
    hold_block <= 1'b0;
    instr_mcs <= 3'h4;
    expect_call(16'h000b, 2'h1);
    instr_mcs <= 3'h1;
    ret_op(1'b1, 2'h0);
    // Edge mode on external zero
    wr(TIMER_CONTROL_REG_OFS, 8'h01);
    repeat (30) @(posedge clk);
    ext0_pin <= 1'b0;
    expect_call(16'h0003, 2'h1);
    rd(TIMER_CONTROL_REG_OFS, 8'h01);
    ret_op(1'b1, 2'h0);
    expect_none(60);
    ext0_pin <= 1'b1;
    wr(TIMER_CONTROL_REG_OFS, 8'h00);
    chk("stack_depth", 16'h0000, {12'h0, stack_depth});
    results();
  end
endmodule
